// *** common/alu_defines.svh ***
/*
 * Offsets, field positions, sizes and reset values of the shift and
 * logic unit. Assumes a 32-bit APB with byte addresses in paddr.
 */
`ifndef ALU_DEFINES_SVH
`define ALU_DEFINES_SVH

`define ALU_PADDR_W 8
`define ALU_OFS_CTRL 8'h00
`define ALU_OFS_ACC 8'h04
`define ALU_OFS_FLAGS 8'h08
`define ALU_OFS_PORT 8'h0c
`define ALU_OFS_MADDR 8'h10
`define ALU_OFS_MDATA 8'h14
`define ALU_OFS_STATUS 8'h18

`define ALU_CTRL_OP_LSB 0
`define ALU_CTRL_FORM_LSB 4
`define ALU_CTRL_IMM_LSB 8
`define ALU_CTRL_ADDR_LSB 16

`define ALU_FLAG_Z 0
`define ALU_FLAG_C 1
`define ALU_FLAG_HC 2
`define ALU_FLAG_SGN_OVF 3
`define ALU_STAT_BUSY 0
`define ALU_STAT_REJECT 1

`define ALU_MEM_AW 4
`define ALU_MEM_DEPTH 16

`define ALU_ACC_RST 8'h00
`define ALU_FLAGS_RST 4'h0
`define ALU_PORT_RST 8'h00

`define ALU_RD_WAIT 2'h2

`endif

// *** common/alu_pkg.sv ***
/*
 * Types of the shift and logic unit: operations, operand forms,
 * sequencer states and the command carrier.
 * Assumes alu_defines.svh is on the include path.
 */
`include "alu_defines.svh"

package alu_pkg;

    typedef enum logic [3:0] {
        op_shr = 4'h0,
        op_rrc = 4'h1,
        op_shl = 4'h2,
        op_rlc = 4'h3,
        op_swap = 4'h4,
        op_and = 4'h5,
        op_or = 4'h6,
        op_xor = 4'h7
    } op_t;

    // f_acc: accumulator alone, or accumulator with immediate
    typedef enum logic [2:0] {
        f_acc = 3'h0,
        f_to_acc = 3'h1,
        f_to_mem = 3'h2,
        f_io_to_acc = 3'h3,
        f_acc_to_io = 3'h4
    } form_t;

    typedef enum logic [2:0] {
        st_idle = 3'b001,
        st_fetch = 3'b010,
        st_exec = 3'b100
    } state_t;

    typedef struct packed {
        logic [`ALU_MEM_AW-1:0] addr;
        logic [7:0] imm;
        form_t form;
        op_t op;
    } cmd_t;

    typedef struct packed {
        logic [7:0] res;
        logic carry;
        logic wr_acc;
        logic wr_mem;
        logic wr_io;
        logic upd_z;
        logic upd_c;
    } alu_out_t;

endpackage

// *** rtl/data_mem.sv ***
/*
 * Small byte memory standing in for the core's data memory.
 * One write port and one read port sharing an address; read data
 * come from a register one clock after the address.
 */
`include "alu_defines.svh"

module data_mem (
    // clock
    input wire logic pclk,
    // access
    input wire logic [`ALU_MEM_AW-1:0] addr,
    input wire logic we,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    logic [7:0] mem [`ALU_MEM_DEPTH];

    // no reset: contents are undefined until software writes them
    always_ff @(posedge pclk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule

// *** rtl/shift_logic_alu.sv ***
/*
 * Shift, rotate, nibble swap and AND/OR/XOR unit of an 8-bit core,
 * with accumulator, flags, port data register and data memory,
 * all reached over APB. Assumes a single clock and a master that
 * holds each request until pready.
 */
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`include "alu_defines.svh"

module shift_logic_alu
    import alu_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`ALU_PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // state seen by the core
    output logic [7:0] accumulator,
    output logic [3:0] flags,
    output logic [7:0] first_port_data_register
);

    function automatic logic cmd_ok(op_t op, form_t form);
        logic ok;
        ok = 1'b0;
        case (op)
            op_shr, op_rrc, op_shl, op_rlc, op_swap: begin
                ok = (form == f_acc) || (form == f_to_mem);
            end
            op_and, op_or: begin
                ok = (form == f_acc) || (form == f_to_acc) ||
                     (form == f_to_mem);
            end
            op_xor: begin
                ok = (form != f_acc_to_io + 3'h1) &&
                     (form <= f_acc_to_io);
            end
            default: begin
                ok = 1'b0;
            end
        endcase
        return ok;
    endfunction

    state_t st, next_st;
    cmd_t cmd, next_cmd;
    logic [7:0] next_acc, next_port;
    logic [3:0] next_flags;
    logic [`ALU_MEM_AW-1:0] maddr, next_maddr;
    logic [1:0] rd_cnt, next_rd_cnt;
    logic [31:0] next_prdata;
    logic reject, next_reject;
    alu_out_t alu;
    logic [7:0] mem_rdata, mem_wdata, shift_src, logic_b;
    logic [`ALU_MEM_AW-1:0] mem_addr;
    logic mem_we;
    logic access, is_read, wr_accept, mapped, ctrl_wr, ctrl_good;
    cmd_t wr_cmd;

    // apb handshake
    assign access = psel & penable;
    assign is_read = access & ~pwrite;
    // everything stalls while an operation runs
    assign pready = (st == st_idle) &&
                    (pwrite || rd_cnt == `ALU_RD_WAIT);
    assign wr_accept = access & pwrite & pready;
    assign mapped = (paddr == `ALU_OFS_CTRL) ||
                    (paddr == `ALU_OFS_ACC) ||
                    (paddr == `ALU_OFS_FLAGS) ||
                    (paddr == `ALU_OFS_PORT) ||
                    (paddr == `ALU_OFS_MADDR) ||
                    (paddr == `ALU_OFS_MDATA) ||
                    (paddr == `ALU_OFS_STATUS);
    assign wr_cmd.op = op_t'(pwdata[`ALU_CTRL_OP_LSB +: 4]);
    assign wr_cmd.form = form_t'(pwdata[`ALU_CTRL_FORM_LSB +: 3]);
    assign wr_cmd.imm = pwdata[`ALU_CTRL_IMM_LSB +: 8];
    assign wr_cmd.addr = pwdata[`ALU_CTRL_ADDR_LSB +: `ALU_MEM_AW];
    assign ctrl_wr = wr_accept && paddr == `ALU_OFS_CTRL;
    assign ctrl_good = cmd_ok(wr_cmd.op, wr_cmd.form);
    assign pslverr = pready & access &
                     (~mapped | (ctrl_wr & ~ctrl_good));

    // operation datapath
    always_comb begin
        shift_src = (cmd.form == f_to_mem) ? mem_rdata : accumulator;
        case (cmd.form)
            f_acc: logic_b = cmd.imm;
            f_to_acc, f_to_mem: logic_b = mem_rdata;
            default: logic_b = first_port_data_register;
        endcase
        alu = '0;
        alu.carry = flags[`ALU_FLAG_C];
        alu.wr_mem = (cmd.form == f_to_mem);
        alu.wr_io = (cmd.form == f_acc_to_io);
        alu.wr_acc = ~alu.wr_mem & ~alu.wr_io;
        case (cmd.op)
            op_shr: begin
                alu.res = {1'b0, shift_src[7:1]};
                alu.carry = shift_src[0];
                alu.upd_c = 1'b1;
            end
            op_rrc: begin
                alu.res = {flags[`ALU_FLAG_C], shift_src[7:1]};
                alu.carry = shift_src[0];
                alu.upd_c = 1'b1;
            end
            op_shl: begin
                alu.res = {shift_src[6:0], 1'b0};
                alu.carry = shift_src[7];
                alu.upd_c = 1'b1;
            end
            op_rlc: begin
                alu.res = {shift_src[6:0], flags[`ALU_FLAG_C]};
                alu.carry = shift_src[7];
                alu.upd_c = 1'b1;
            end
            op_swap: begin
                alu.res = {shift_src[3:0], shift_src[7:4]};
            end
            op_and: begin
                alu.res = accumulator & logic_b;
                alu.upd_z = 1'b1;
            end
            op_or: begin
                alu.res = accumulator | logic_b;
                alu.upd_z = 1'b1;
            end
            op_xor: begin
                alu.res = accumulator ^ logic_b;
                alu.upd_z = ~alu.wr_io;
            end
            default: begin
                alu.res = accumulator;
            end
        endcase
    end

    // memory shared between operations and software
    assign mem_addr = (st == st_idle) ? maddr : cmd.addr;
    assign mem_we = ((st == st_exec) & alu.wr_mem) |
                    (wr_accept && paddr == `ALU_OFS_MDATA);
    assign mem_wdata = (st == st_exec) ? alu.res : pwdata[7:0];

    data_mem u_data_mem (
        .pclk(pclk),
        .addr(mem_addr),
        .we(mem_we),
        .wdata(mem_wdata),
        .rdata(mem_rdata)
    );

    always_comb begin
        next_st = st;
        next_cmd = cmd;
        next_acc = accumulator;
        next_flags = flags;
        next_port = first_port_data_register;
        next_maddr = maddr;
        next_reject = reject;
        next_prdata = prdata;
        next_rd_cnt = rd_cnt;
        if (is_read && st == st_idle) begin
            next_rd_cnt = (rd_cnt == `ALU_RD_WAIT) ? 2'h0 : rd_cnt + 2'h1;
        end
        // captured one cycle before pready so memory data has arrived
        if (is_read && st == st_idle && rd_cnt == 2'h1) begin
            case (paddr)
                `ALU_OFS_CTRL: next_prdata = 32'(cmd);
                `ALU_OFS_ACC: next_prdata = {24'h0, accumulator};
                `ALU_OFS_FLAGS: next_prdata = {28'h0, flags};
                `ALU_OFS_PORT: next_prdata = {24'h0,
                                              first_port_data_register};
                `ALU_OFS_MADDR: next_prdata = 32'(maddr);
                `ALU_OFS_MDATA: next_prdata = {24'h0, mem_rdata};
                `ALU_OFS_STATUS: next_prdata = {30'h0, reject, 1'b0};
                default: next_prdata = 32'h0;
            endcase
        end
        if (wr_accept) begin
            case (paddr)
                `ALU_OFS_ACC: next_acc = pwdata[7:0];
                `ALU_OFS_FLAGS: next_flags = pwdata[3:0];
                `ALU_OFS_PORT: next_port = pwdata[7:0];
                `ALU_OFS_MADDR: next_maddr = pwdata[`ALU_MEM_AW-1:0];
                default: begin
                end
            endcase
        end
        case (st)
            st_idle: begin
                if (ctrl_wr) begin
                    next_reject = ~ctrl_good;
                    if (ctrl_good) begin
                        next_cmd = wr_cmd;
                        next_st = (wr_cmd.form == f_to_acc ||
                                   wr_cmd.form == f_to_mem) ?
                                  st_fetch : st_exec;
                    end
                end
            end
            st_fetch: begin
                next_st = st_exec;
            end
            st_exec: begin
                next_st = st_idle;
                if (alu.wr_acc) begin
                    next_acc = alu.res;
                end
                if (alu.wr_io) begin
                    next_port = alu.res;
                end
                if (alu.upd_c) begin
                    next_flags[`ALU_FLAG_C] = alu.carry;
                end
                if (alu.upd_z) begin
                    next_flags[`ALU_FLAG_Z] = (alu.res == 8'h00);
                end
            end
            default: begin
                next_st = st_idle;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= st_idle;
            cmd <= '0;
            accumulator <= `ALU_ACC_RST;
            flags <= `ALU_FLAGS_RST;
            first_port_data_register <= `ALU_PORT_RST;
            maddr <= '0;
            reject <= 1'b0;
            prdata <= 32'h0;
            rd_cnt <= 2'h0;
        end else begin
            st <= next_st;
            cmd <= next_cmd;
            accumulator <= next_acc;
            flags <= next_flags;
            first_port_data_register <= next_port;
            maddr <= next_maddr;
            reject <= next_reject;
            prdata <= next_prdata;
            rd_cnt <= next_rd_cnt;
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic ex_acc;
    assign ex_acc = (st == st_exec) && cmd.form == f_acc;

    property p_shr;
        ex_acc && cmd.op == op_shr |=> accumulator ==
            {1'b0, $past(accumulator[7:1])} &&
            flags[`ALU_FLAG_C] == $past(accumulator[0]);
    endproperty
    a_shr: assert property (p_shr)
        else $error("shift right result wrong");

    property p_rrc;
        ex_acc && cmd.op == op_rrc |=> accumulator ==
            {$past(flags[`ALU_FLAG_C]), $past(accumulator[7:1])};
    endproperty
    a_rrc: assert property (p_rrc)
        else $error("rotate right result wrong");

    property p_shl;
        ex_acc && cmd.op == op_shl |=> accumulator ==
            {$past(accumulator[6:0]), 1'b0} &&
            flags[`ALU_FLAG_C] == $past(accumulator[7]);
    endproperty
    a_shl: assert property (p_shl)
        else $error("shift left result wrong");

    property p_rlc;
        ex_acc && cmd.op == op_rlc |=> accumulator ==
            {$past(accumulator[6:0]), $past(flags[`ALU_FLAG_C])};
    endproperty
    a_rlc: assert property (p_rlc)
        else $error("rotate left result wrong");

    property p_mem_back;
        ctrl_wr && ctrl_good && wr_cmd.form == f_to_mem |=>
            ##1 (mem_we && mem_addr == $past(wr_cmd.addr, 2)) ##1
            $stable(accumulator);
    endproperty
    a_mem_back: assert property (p_mem_back)
        else $error("memory form did not write back");

    property p_shift_flags;
        st == st_exec && cmd.op <= op_rlc |=>
            $stable(flags[`ALU_FLAG_Z]) && $stable(flags[3:2]);
    endproperty
    a_shift_flags: assert property (p_shift_flags)
        else $error("shift touched a flag other than carry");

    property p_swap;
        ex_acc && cmd.op == op_swap |=> $stable(flags) &&
            accumulator == {$past(accumulator[3:0]),
                            $past(accumulator[7:4])};
    endproperty
    a_swap: assert property (p_swap)
        else $error("nibble swap wrong");

    property p_io_xor;
        st == st_exec && cmd.form == f_acc_to_io |=> $stable(flags) &&
            first_port_data_register == ($past(accumulator) ^
            $past(first_port_data_register));
    endproperty
    a_io_xor: assert property (p_io_xor)
        else $error("port xor wrong or flags changed");

    property p_zero;
        st == st_exec && cmd.op >= op_and && alu.wr_acc |=>
            flags[`ALU_FLAG_Z] == (accumulator == 8'h00) &&
            $stable(flags[3:1]);
    endproperty
    a_zero: assert property (p_zero)
        else $error("zero flag wrong after logic op");

    c_mem_shift: cover property (st == st_exec && cmd.form == f_to_mem
                                 && cmd.op == op_rlc);
    c_io_xor: cover property (st == st_exec && cmd.form == f_acc_to_io);
    c_mem_read: cover property (is_read && pready &&
                                paddr == `ALU_OFS_MDATA);
    c_reject: cover property (ctrl_wr && !ctrl_good);
endmodule

// *** sim/core_apb_model.sv ***
/*
 * Behavioural core side of the shift and logic unit: it issues
 * register transfers over APB, one at a time.
 * Assumes the unit answers with pready and pslverr on pclk.
 */
`include "alu_defines.svh"

module core_apb_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb master
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [`ALU_PADDR_W-1:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
    end

    // tmo flags a slave that never answered; the caller decides
    task automatic xfer(input logic wr, input logic [`ALU_PADDR_W-1:0] a,
        input logic [31:0] wd, output logic [31:0] rd, output logic err,
        output logic tmo);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        rd = prdata;
        err = pslverr;
        tmo = (pready !== 1'b1) || (presetn !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

// *** sim/shift_logic_alu_tb_top.sv ***
/*
 * Self-checking bench of the shift and logic unit: every operation
 * in every form, fixed corners then random operands.
 * Assumes the register map and command layout of the unit's header.
 */
`include "alu_defines.svh"

module shift_logic_alu_tb_top import alu_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [`ALU_PADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0] accumulator, first_port_data_register;
    logic [3:0] flags;
    int error_cnt, n_compared;

    shift_logic_alu u_shift_logic_alu (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .accumulator(accumulator),
        .flags(flags), .first_port_data_register(first_port_data_register)
    );

    core_apb_model u_core_apb_model (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr)
    );

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
        input string what);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s: saw %h expected %h", $time, what,
                seen, exp);
        end
    endtask

    task automatic close_out();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic bus(input logic wr, input logic [7:0] a,
        input logic [31:0] wd, output logic [31:0] rd, output logic err);
        logic tmo;
        u_core_apb_model.xfer(wr, a, wd, rd, err, tmo);
        if (tmo) begin
            error_cnt++;
            $display("[FAIL] %0t no pready", $time);
            close_out();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        bus(1'b1, a, d, rd, err);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
        input string what);
        logic [31:0] rd;
        logic err;
        bus(1'b0, a, 32'h0, rd, err);
        check(rd, exp, what);
    endtask

    // shifts and swap take forms 0 and 2, and/or 0..2, xor 0..4
    function automatic logic legal(int op, int f);
        if (op > 7) begin
            return 1'b0;
        end
        if (op < 5) begin
            return f == 0 || f == 2;
        end
        return (op < 7) ? f <= 2 : f <= 4;
    endfunction

    function automatic void predict(input op_t op, input form_t f,
        input logic [7:0] im, inout logic [7:0] a, m, p,
        inout logic [3:0] fl);
        logic [7:0] s, r;
        logic c;
        s = (f == f_to_mem) ? m : a;
        c = fl[`ALU_FLAG_C];
        case (op)
            op_shr: {r, fl[`ALU_FLAG_C]} = {1'b0, s};
            op_rrc: {r, fl[`ALU_FLAG_C]} = {c, s};
            op_shl: {fl[`ALU_FLAG_C], r} = {s, 1'b0};
            op_rlc: {fl[`ALU_FLAG_C], r} = {s, c};
            op_swap: r = {s[3:0], s[7:4]};
            default: begin
                s = (f == f_acc) ? im : (f >= f_io_to_acc) ? p : m;
                r = (op == op_and) ? a & s : (op == op_or) ? a | s : a ^ s;
                // xor into the port leaves every flag
                if (f != f_acc_to_io) begin
                    fl[`ALU_FLAG_Z] = (r == 8'h00);
                end
            end
        endcase
        // memory form writes back to the same byte
        if (f == f_to_mem) begin
            m = r;
        end else if (f == f_acc_to_io) begin
            p = r;
        end else begin
            a = r;
        end
    endfunction

    initial begin
        logic [31:0] rd;
        logic err, ok;
        logic [7:0] a, m, p, im;
        logic [3:0] fl, ad;
        error_cnt = 0;
        n_compared = 0;
        presetn = 1'b0;
        void'($urandom(32'hb3a02dda));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(`ALU_OFS_ACC, 32'(`ALU_ACC_RST), "acc after reset");
        rd_chk(`ALU_OFS_FLAGS, 32'(`ALU_FLAGS_RST), "flags after reset");
        rd_chk(`ALU_OFS_PORT, 32'(`ALU_PORT_RST), "port after reset");
        bus(1'b0, 8'h1c, 32'h0, rd, err);
        check(32'(err), 32'h1, "unmapped address");
        for (int pass = 0; pass < 6; pass++) begin
            for (int op = 0; op < 16; op++) begin
                for (int f = 0; f < 8; f++) begin
                    // first pass: equal bytes give zero results, edge bits
                    if (pass == 0) begin
                        {a, m, p, im, fl, ad} = {32'h8181817e, 8'hdf};
                    end else begin
                        {a, m, p, im} = $urandom;
                        {fl, ad} = 8'($urandom);
                    end
                    wr(`ALU_OFS_ACC, 32'(a));
                    wr(`ALU_OFS_PORT, 32'(p));
                    wr(`ALU_OFS_FLAGS, 32'(fl));
                    wr(`ALU_OFS_MADDR, 32'(ad));
                    wr(`ALU_OFS_MDATA, 32'(m));
                    ok = legal(op, f);
                    bus(1'b1, `ALU_OFS_CTRL,
                        {12'h0, ad, im, 1'b0, f[2:0], op[3:0]}, rd, err);
                    check(32'(err), 32'(!ok), "refusal");
                    if (ok) begin
                        predict(op_t'(op[3:0]), form_t'(f[2:0]), im, a, m, p,
                            fl);
                    end
                    rd_chk(`ALU_OFS_STATUS, {30'h0, !ok, 1'b0}, "status");
                    rd_chk(`ALU_OFS_ACC, 32'(a), "acc read");
                    check(32'(accumulator), 32'(a), "acc");
                    check(32'(flags), 32'(fl), "flags");
                    check(32'(first_port_data_register), 32'(p),
                        "port");
                    rd_chk(`ALU_OFS_MDATA, 32'(m), "memory");
                end
            end
        end
        close_out();
    end
endmodule
